// >>> bif_pkg.sv
// ==========================================
// Shared constants and types
package bif_pkg;
  localparam int ADDR_W = 20;
  localparam int DATA_W = 8;
  localparam int IO_ADDR_W = 16;
  localparam int REFRESH_STROBE_N_W = 8;
  localparam int XFER_CH = 2;
  localparam logic [19:0] NMI_VECTOR = 20'h00066;
  localparam logic [19:0] SLEEP_ADDR = 20'hFFFFF;
  localparam logic [19:0] ADDR_RESET = 20'h00000;
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam logic [7:0] REFRESH_STROBE_N_RESET = 8'h00;
  localparam logic [7:0] REFRESH_STROBE_N_STEP = 8'h01;
  localparam logic [3:0] IO_TOP_ZERO = 4'h0;
  localparam logic [11:0] REFRESH_STROBE_N_TOP_ZERO = 12'h000;

  // ==========================================
  // Machine cycle kinds requested by the core
  typedef enum logic [3:0] {
    K_FETCH1 = 4'h0,
    K_FETCH23 = 4'h1,
    K_MRD = 4'h2,
    K_MWR = 4'h3,
    K_IORD = 4'h4,
    K_IOWR = 4'h5,
    K_ACK0 = 4'h6,
    K_ACK12 = 4'h7,
    K_REFRESH = 4'h8,
    K_DMARD = 4'h9,
    K_DMAWR = 4'hA
  } bif_kind_t;

  typedef enum logic [1:0] {
    M_RUN = 2'h0,
    M_HALT = 2'h1,
    M_SLEEP = 2'h2
  } bif_mode_t;

  typedef enum logic [6:0] {
    S_IDLE = 7'h01,
    S_T1 = 7'h02,
    S_T2 = 7'h04,
    S_TW = 7'h08,
    S_T3 = 7'h10,
    S_GRANT = 7'h20,
    S_REGAIN = 7'h40
  } bif_state_t;

  typedef struct packed {
    logic valid;
    bif_kind_t kind;
    logic [19:0] addr;
    logic [7:0] wdata;
    logic chan;
    logic last;
  } bif_req_t;

  typedef struct packed {
    logic io_n;
    logic mem_n;
    logic rd_n;
    logic wr_n;
  } bif_strobe_t;

  typedef struct packed {
    logic nmi;
    logic irq0;
    logic irq12;
  } bif_take_t;

  localparam bif_strobe_t STROBE_IDLE = 4'hF;
  localparam bif_take_t TAKE_NONE = 3'h0;
endpackage : bif_pkg

// >>> bif_bus_ctrl.sv
`timescale 1ns/1ns
// Function
// - Drive 20-bit address; memory reaches 1 MB, I/O 64 KB.
// - Address and data float during reset and while bus is granted.
// - Address bit 18 shared with timer pulse; address after reset.
// - Hold request taken at machine cycle end, above NMI; buses float.
// - Grant output low tells master the buses are floating.
// - System clock output is half the input clock.
// - Transfer requests sensed as level or edge per channel.
// - Request 0 taken when no NMI or hold; ack has first-cycle and I/O.
// - Requests 1, 2 only when NMI, hold, request 0 idle; plain ack.
// - NMI falling edge latched, taken ahead of maskable requests.
// - I/O and memory strobes mark valid I/O or memory address.
// - First-cycle strobe with memory on fetch, with I/O on ack.
// - Write strobe low only while data bus carries valid data.
// - Refresh strobe with memory strobe, refresh address on low 8 bits.
// - Wait sampled at T2 falling edge and each wait state.
// - Stop indicator low during halt or sleep until wakeup.
// - Status 0,1,0 first fetch; 1,1,0 later fetches and request 0 ack; 1,1,1 others.
// - Status 0,X,1 DMA; 0,0,0 halt (0,0,1 while bus is granted); 1,0,1 sleep.
// - Transfer-end low during final DMA write cycle.
// - Pin levels in reset, grant and sleep as tabulated.
// - Enable clock marks machine cycles during bus transfers.
module bif_bus_ctrl (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire bif_pkg::bif_req_t req,
  output logic req_ack,
  output logic [7:0] rdata,
  input wire bif_pkg::bif_mode_t cpu_mode,
  input wire logic instr_end,
  input wire logic int_enable,
  output bif_pkg::bif_take_t take,
  input wire logic [1:0] xfer_edge_mode,
  output logic [1:0] xfer_ready,
  input wire logic timer_out_sel,
  input wire logic reload_timer_pulse,
  output logic [19:0] addr_out,
  output logic addr_oe,
  input wire logic [7:0] data_in,
  output logic [7:0] data_out,
  output logic data_oe,
  output bif_pkg::bif_strobe_t strobe_out,
  output logic strobe_oe,
  output logic refresh_strobe_n,
  output logic first_cycle_strobe_n,
  output logic grant_n,
  input wire logic hold_request_n,
  input wire logic wait_n,
  input wire logic nmi_n,
  input wire logic vectored_irq_zero_n,
  input wire logic plain_irq_one_n,
  input wire logic plain_irq_two_n,
  input wire logic xfer_request_zero_n,
  input wire logic xfer_request_one_n,
  output logic xfer_done_zero_n,
  output logic xfer_done_one_n,
  output logic cycle_kind_flag,
  output logic stop_n,
  output logic enable_clk_out,
  output logic system_clock_out
);
  import bif_pkg::*;

  // ==========================================
  // Sequencer
  bif_state_t state_reg, state_next;
  logic phase_reg, phase_next;
  bif_req_t cur_reg, cur_next;
  logic wait_seen_reg, wait_seen_next;
  logic [7:0] refresh_strobe_n_reg, refresh_strobe_n_next;
  logic ack_reg, ack_next;
  logic [7:0] rdata_reg, rdata_next;
  logic hold, end_t;

  assign hold = ~hold_request_n;
  assign end_t = phase_reg;

  always_comb
  begin
    state_next = state_reg;
    phase_next = ~phase_reg;
    cur_next = cur_reg;
    wait_seen_next = wait_seen_reg;
    refresh_strobe_n_next = refresh_strobe_n_reg;
    ack_next = 1'b0;
    rdata_next = rdata_reg;
    case (state_reg)
      S_IDLE:
      begin
        if (end_t && hold)
          state_next = S_GRANT;
        else if (end_t && req.valid && cpu_mode == M_RUN)
        begin
          cur_next = req;
          state_next = S_T1;
        end
      end
      S_T1:
        if (end_t)
          state_next = S_T2;
      S_T2, S_TW:
      begin
        if (!phase_reg)
          wait_seen_next = ~wait_n;
        if (end_t)
          state_next = wait_seen_reg ? S_TW : S_T3;
      end
      S_T3:
        if (end_t)
        begin
          ack_next = 1'b1;
          rdata_next = data_in;
          if (cur_reg.kind == K_REFRESH)
            refresh_strobe_n_next = refresh_strobe_n_reg + REFRESH_STROBE_N_STEP;
          state_next = hold ? S_GRANT : S_IDLE;
        end
      S_GRANT:
        if (end_t && !hold)
          state_next = S_REGAIN;
      S_REGAIN:
        if (end_t)
          state_next = S_IDLE;
      default:
        state_next = S_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_reg <= S_IDLE;
      phase_reg <= 1'b0;
      cur_reg <= '0;
      wait_seen_reg <= 1'b0;
      refresh_strobe_n_reg <= REFRESH_STROBE_N_RESET;
      ack_reg <= 1'b0;
      rdata_reg <= DATA_RESET;
    end
    else if (clk_en)
    begin
      state_reg <= state_next;
      phase_reg <= phase_next;
      cur_reg <= cur_next;
      wait_seen_reg <= wait_seen_next;
      refresh_strobe_n_reg <= refresh_strobe_n_next;
      ack_reg <= ack_next;
      rdata_reg <= rdata_next;
    end
  end

  assign req_ack = ack_reg;
  assign rdata = rdata_reg;

  // ==========================================
  // Pin decode
  logic bus, floating, is_io, is_mem, is_rd, is_wr, is_dma;
  logic [19:0] addr_next, addr_reg;
  logic addr_oe_next, addr_oe_reg, doe_next, doe_reg, soe_next, soe_reg;
  logic [7:0] dout_reg;
  bif_strobe_t strb_next, strb_reg;
  logic refresh_strobe_n_n_next, refresh_strobe_n_n_reg, m1_next, m1_reg, grant_next, grant_reg;
  logic e_next, e_reg, st_next, st_reg, stop_next, stop_reg;
  logic [1:0] done_next, done_reg;
  logic sysclk_reg, sel_reg;

  always_comb
  begin
    bus = (state_next == S_T1) || (state_next == S_T2) || (state_next == S_TW) ||
          (state_next == S_T3);
    floating = (state_next == S_GRANT);
    is_io = cur_next.kind inside {K_IORD, K_IOWR, K_ACK0};
    is_mem = cur_next.kind inside {K_FETCH1, K_FETCH23, K_MRD, K_MWR, K_REFRESH,
                                   K_DMARD, K_DMAWR};
    is_rd = cur_next.kind inside {K_FETCH1, K_FETCH23, K_MRD, K_IORD, K_DMARD};
    is_wr = cur_next.kind inside {K_MWR, K_IOWR, K_DMAWR};
    is_dma = cur_next.kind inside {K_DMARD, K_DMAWR};
    addr_next = addr_reg;
    if (bus && is_io)
      addr_next = {IO_TOP_ZERO, cur_next.addr[15:0]};
    else if (bus && cur_next.kind == K_REFRESH)
      addr_next = {REFRESH_STROBE_N_TOP_ZERO, refresh_strobe_n_reg};
    else if (bus)
      addr_next = cur_next.addr;
    else if (cpu_mode == M_SLEEP)
      addr_next = SLEEP_ADDR;
    if (sel_reg)
      addr_next[18] = reload_timer_pulse;
    addr_oe_next = ~floating;
    soe_next = ~floating;
    doe_next = bus && is_wr && !floating;
    grant_next = ~floating;
    strb_next = STROBE_IDLE;
    if (bus)
    begin
      strb_next.io_n = ~is_io;
      strb_next.mem_n = ~is_mem;
      strb_next.rd_n = ~(is_rd || cur_next.kind == K_ACK0);
      strb_next.wr_n = ~(is_wr && state_next != S_T1);
    end
    refresh_strobe_n_n_next = ~(bus && cur_next.kind == K_REFRESH);
    e_next = (state_next == S_T2) || (state_next == S_TW) ||
             (state_next == S_T3);
    done_next = 2'h3;
    if (bus && cur_next.kind == K_DMAWR && cur_next.last)
      done_next[cur_next.chan] = 1'b0;
    if (bus && is_dma)
    begin
      st_next = 1'b0;
      stop_next = 1'b1;
      m1_next = 1'b1;
    end
    else if (bus)
    begin
      st_next = (cur_next.kind != K_FETCH1);
      stop_next = 1'b1;
      m1_next = ~(cur_next.kind inside {K_FETCH1, K_FETCH23, K_ACK0});
    end
    else if (cpu_mode == M_HALT)
    begin
      st_next = 1'b0;
      stop_next = 1'b0;
      m1_next = floating;
    end
    else if (cpu_mode == M_SLEEP)
    begin
      st_next = 1'b1;
      stop_next = 1'b0;
      m1_next = 1'b1;
    end
    else
    begin
      st_next = 1'b1;
      stop_next = 1'b1;
      m1_next = 1'b1;
    end
  end

  // Reset levels: strobes high, buses floating, enable clock low
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      addr_reg <= ADDR_RESET;
      addr_oe_reg <= 1'b0;
      dout_reg <= DATA_RESET;
      doe_reg <= 1'b0;
      soe_reg <= 1'b1;
      strb_reg <= STROBE_IDLE;
      refresh_strobe_n_n_reg <= 1'b1;
      m1_reg <= 1'b1;
      grant_reg <= 1'b1;
      e_reg <= 1'b0;
      st_reg <= 1'b1;
      stop_reg <= 1'b1;
      done_reg <= 2'h3;
      sysclk_reg <= 1'b0;
      sel_reg <= 1'b0;
    end
    else if (clk_en)
    begin
      addr_reg <= addr_next;
      addr_oe_reg <= addr_oe_next;
      dout_reg <= cur_next.wdata;
      doe_reg <= doe_next;
      soe_reg <= soe_next;
      strb_reg <= strb_next;
      refresh_strobe_n_n_reg <= refresh_strobe_n_n_next;
      m1_reg <= m1_next;
      grant_reg <= grant_next;
      e_reg <= e_next;
      st_reg <= st_next;
      stop_reg <= stop_next;
      done_reg <= done_next;
      sysclk_reg <= ~sysclk_reg;
      sel_reg <= timer_out_sel;
    end
  end

  assign addr_out = addr_reg;
  assign addr_oe = addr_oe_reg;
  assign data_out = dout_reg;
  assign data_oe = doe_reg;
  assign strobe_out = strb_reg;
  assign strobe_oe = soe_reg;
  assign refresh_strobe_n = refresh_strobe_n_n_reg;
  assign first_cycle_strobe_n = m1_reg;
  assign grant_n = grant_reg;
  assign enable_clk_out = e_reg;
  assign cycle_kind_flag = st_reg;
  assign stop_n = stop_reg;
  assign xfer_done_zero_n = done_reg[0];
  assign xfer_done_one_n = done_reg[1];
  assign system_clock_out = sysclk_reg;

  // ==========================================
  // Interrupt acceptance
  logic nmi_prev_reg, nmi_prev_next, nmi_pend_reg, nmi_pend_next;
  bif_take_t take_reg, take_next;

  always_comb
  begin
    nmi_prev_next = nmi_n;
    take_next = TAKE_NONE;
    if (instr_end && !hold)
    begin
      if (nmi_pend_reg)
        take_next.nmi = 1'b1;
      else if (int_enable && !vectored_irq_zero_n)
        take_next.irq0 = 1'b1;
      else if (int_enable && (!plain_irq_one_n || !plain_irq_two_n))
        take_next.irq12 = 1'b1;
    end
    nmi_pend_next = (nmi_prev_reg & ~nmi_n) | (nmi_pend_reg & ~take_next.nmi);
  end

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      nmi_prev_reg <= 1'b1;
      nmi_pend_reg <= 1'b0;
      take_reg <= TAKE_NONE;
    end
    else if (clk_en)
    begin
      nmi_prev_reg <= nmi_prev_next;
      nmi_pend_reg <= nmi_pend_next;
      take_reg <= take_next;
    end
  end

  assign take = take_reg;

  // ==========================================
  // Transfer request sensing per channel
  logic [1:0] xreq_n;
  assign xreq_n = {xfer_request_one_n, xfer_request_zero_n};

  for (genvar c = 0; c < XFER_CH; c++)
  begin : g_xfer
    logic prev_reg, prev_next, edge_reg, edge_next, rdy_reg, rdy_next, used;
    always_comb
    begin
      used = (state_reg == S_T3) && end_t && (cur_reg.chan == c) &&
             (cur_reg.kind inside {K_DMARD, K_DMAWR});
      prev_next = xreq_n[c];
      edge_next = (prev_reg & ~xreq_n[c]) | (edge_reg & ~used);
      rdy_next = xfer_edge_mode[c] ? edge_next : ~xreq_n[c];
    end
    always_ff @(posedge core_clk or negedge reset_n)
    begin
      if (!reset_n)
      begin
        prev_reg <= 1'b1;
        edge_reg <= 1'b0;
        rdy_reg <= 1'b0;
      end
      else if (clk_en)
      begin
        prev_reg <= prev_next;
        edge_reg <= edge_next;
        rdy_reg <= rdy_next;
      end
    end
    assign xfer_ready[c] = rdy_reg;
  end

  // ==========================================
  // Checks
  float_bus_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    state_reg == S_GRANT |-> !addr_oe && !data_oe && !strobe_oe && !grant_n)
    else $error("buses driven during grant");
  regain_order_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    $rose(grant_n) |-> addr_oe && state_reg == S_REGAIN)
    else $error("grant released without bus regain");
  refresh_pair_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    !refresh_strobe_n |-> !strobe_out.mem_n && addr_out[19:8] == 12'h000)
    else $error("refresh without memory strobe or address");
  io_range_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    !strobe_out.io_n && !sel_reg |-> addr_out[19:16] == 4'h0)
    else $error("io address above 64 KB");
  write_data_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    !strobe_out.wr_n |-> data_oe)
    else $error("write strobe without data");
  sys_clock_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    clk_en && reset_n |=> system_clock_out != $past(system_clock_out))
    else $error("system clock did not toggle");
  wait_state_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    clk_en && state_reg == S_T2 && phase_reg && wait_seen_reg |=> state_reg == S_TW)
    else $error("wait state not inserted");
  nmi_first_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    clk_en && instr_end && nmi_pend_reg && hold_request_n |=> take.nmi && !take.irq0)
    else $error("pending nmi not taken first");
  ack_zero_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    state_reg == S_T3 && cur_reg.kind == K_ACK0 |-> !first_cycle_strobe_n && !strobe_out.io_n)
    else $error("request 0 ack strobes wrong");
  xfer_end_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    !xfer_done_zero_n || !xfer_done_one_n |-> !strobe_out.mem_n && cycle_kind_flag == 1'b0)
    else $error("transfer end outside dma cycle");
endmodule : bif_bus_ctrl

// >>> bif_mem_model.sv
`timescale 1ns/1ns
// ==========================================
// Memory and I/O partner on the external bus
module bif_mem_model (
  input wire logic core_clk,
  input wire bif_pkg::bif_strobe_t strobe_out,
  input wire logic [19:0] addr_out,
  input wire logic [7:0] wait_lim,
  output logic [7:0] data_in,
  output logic wait_n
);
  import bif_pkg::*;
  logic [7:0] cnt_reg = 8'h00;
  logic [7:0] last_reg = 8'h3C;
  logic sel;
  assign sel = !strobe_out.mem_n || !strobe_out.io_n;
  always_ff @(posedge core_clk)
  begin
    cnt_reg <= sel ? cnt_reg + 8'h01 : 8'h00;
    last_reg <= data_in;
  end
  // Data only while read strobe is low, a changing pattern otherwise
  assign data_in = (sel && !strobe_out.rd_n) ? addr_out[7:0] ^ 8'hA5 : ~last_reg;
  // Slow device holds wait low until its count runs out
  assign wait_n = !(sel && cnt_reg < wait_lim);
endmodule : bif_mem_model

// >>> tb_top.sv
`timescale 1ns/1ns
// ==========================================
// Bench for the external bus interface
module tb_top;
  import bif_pkg::*;
  logic core_clk, reset_n, clk_en, req_ack, instr_end, int_enable, timer_out_sel;
  logic reload_timer_pulse, addr_oe, data_oe, strobe_oe, refresh_strobe_n, first_cycle_strobe_n;
  logic grant_n, hold_request_n, wait_n, nmi_n, vectored_irq_zero_n, plain_irq_one_n;
  logic plain_irq_two_n, xfer_request_zero_n, xfer_request_one_n, xfer_done_zero_n;
  logic xfer_done_one_n, cycle_kind_flag, stop_n, enable_clk_out, system_clock_out, rf_seen;
  logic [1:0] xfer_edge_mode, xfer_ready;
  logic [7:0] rdata, data_in, data_out, wait_lim, rf_prev;
  logic [19:0] addr_out;
  bif_req_t req;
  bif_mode_t cpu_mode;
  bif_take_t take;
  bif_strobe_t strobe_out;
  int failures, check_count;

  bif_bus_ctrl u_dut (.core_clk, .reset_n, .clk_en, .req, .req_ack, .rdata, .cpu_mode,
    .instr_end, .int_enable, .take, .xfer_edge_mode, .xfer_ready, .timer_out_sel,
    .reload_timer_pulse, .addr_out, .addr_oe, .data_in, .data_out, .data_oe, .strobe_out,
    .strobe_oe, .refresh_strobe_n, .first_cycle_strobe_n, .grant_n, .hold_request_n, .wait_n,
    .nmi_n, .vectored_irq_zero_n, .plain_irq_one_n, .plain_irq_two_n, .xfer_request_zero_n,
    .xfer_request_one_n, .xfer_done_zero_n, .xfer_done_one_n, .cycle_kind_flag, .stop_n,
    .enable_clk_out, .system_clock_out);
  bif_mem_model u_mem (.core_clk, .strobe_out, .addr_out, .wait_lim, .data_in, .wait_n);

  // ==========================================
  // Clock, compare and closing
  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    if (got !== exp)
    begin
      $display("BAD t=%0t got=%0h exp=%0h", $time, got, exp);
      failures++;
    end
    check_count++;
  endtask : check

  task automatic complete_run;
    $display("checks=%0d mismatches=%0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : complete_run

  initial
  begin
    repeat (20000) @(posedge core_clk);
    failures++;
    complete_run;
  end

  // ==========================================
  // One bus cycle: status, length, address, data
  task automatic cyc(input bif_kind_t k, input logic [19:0] a, input logic [7:0] w, input int wt);
    logic [7:0] snap, ex, mk;
    logic [19:0] sa, ea;
    logic [8:0] sd;
    logic [1:0] dn;
    int n;
    n = 0;
    @(posedge core_clk);
    wait_lim <= 8'(2 * wt + 1);
    req <= '{1'b1, k, a, w, 1'b1, 1'b1};
    for (int i = 0; i < 300; i++)
    begin
      @(negedge core_clk);
      if (enable_clk_out && n == 0)
      begin
        snap = {strobe_out, first_cycle_strobe_n, refresh_strobe_n, cycle_kind_flag, stop_n};
        sa = addr_out;
        sd = {data_oe, data_out};
        dn = {xfer_done_zero_n, xfer_done_one_n};
      end
      if (enable_clk_out)
        n++;
      if (req_ack)
        break;
    end
    check(req_ack, 1'b1);
    mk = (k == K_ACK0) ? 8'hFD : 8'hFF;
    case (k)
      K_FETCH1: ex = 8'h95;
      K_FETCH23: ex = 8'h97;
      K_MWR: ex = 8'hAF;
      K_IORD: ex = 8'h5F;
      K_IOWR: ex = 8'h6F;
      K_ACK0: ex = 8'h57;
      K_ACK12: ex = 8'hFF;
      K_REFRESH: ex = 8'hBB;
      K_DMARD: ex = 8'h9D;
      K_DMAWR: ex = 8'hAD;
      default: ex = 8'h9F;
    endcase
    check(snap & mk, ex & mk);
    // A plain ack selects no device, so nothing holds wait low
    check(n, (k == K_ACK12) ? 4 : 4 + 2 * wt);
    check(dn, {1'b1, k != K_DMAWR});
    ea = (k inside {K_IORD, K_IOWR}) ? {4'h0, a[15:0]} : a;
    if (timer_out_sel)
      ea[18] = reload_timer_pulse;
    if (k == K_REFRESH)
    begin
      check(sa[19:8], REFRESH_STROBE_N_TOP_ZERO);
      if (rf_seen)
        check(sa[7:0], rf_prev + REFRESH_STROBE_N_STEP);
      rf_prev = sa[7:0];
      rf_seen = 1'b1;
    end
    else if (k != K_ACK0 && k != K_ACK12)
      check(sa, ea);
    if (k inside {K_MWR, K_IOWR, K_DMAWR})
      check(sd, {1'b1, w});
    if (k inside {K_FETCH1, K_FETCH23, K_MRD, K_IORD, K_DMARD})
      check(rdata, a[7:0] ^ 8'hA5);
    @(posedge core_clk);
    req.valid <= 1'b0;
  endtask : cyc

  // ==========================================
  // Scenarios
  task automatic t_clk;
    logic p;
    @(negedge core_clk);
    p = system_clock_out;
    repeat (4)
    begin
      @(negedge core_clk);
      check(system_clock_out, !p);
      p = system_clock_out;
    end
    // Last enabled edge still toggles, then the clock freezes
    @(posedge core_clk);
    clk_en <= 1'b0;
    repeat (3) @(negedge core_clk);
    check(system_clock_out, !p);
    @(posedge core_clk);
    clk_en <= 1'b1;
    $display("clock test done");
  endtask : t_clk

  task automatic t_kinds;
    bif_kind_t kl[12] = '{K_FETCH1, K_FETCH23, K_MRD, K_MWR, K_IORD, K_IOWR, K_ACK0,
      K_ACK12, K_REFRESH, K_REFRESH, K_DMARD, K_DMAWR};
    for (int i = 0; i < 12; i++)
      cyc(kl[i], 20'hF1230 + 20'(i), 8'h3C + 8'(i), i % 3);
    @(posedge core_clk);
    {timer_out_sel, reload_timer_pulse} <= 2'b11;
    cyc(K_MRD, 20'h00000, 8'h00, 0);
    timer_out_sel <= 1'b0;
    $display("cycle kinds test done");
  endtask : t_kinds

  task automatic t_hold;
    @(posedge core_clk);
    hold_request_n <= 1'b0;
    req <= '{1'b1, K_MRD, 20'h00010, 8'h00, 1'b1, 1'b0};
    for (int i = 0; i < 50 && grant_n; i++) @(negedge core_clk);
    repeat (10) @(negedge core_clk);
    check({grant_n, addr_oe, data_oe, strobe_oe, enable_clk_out}, 5'h00);
    @(posedge core_clk);
    hold_request_n <= 1'b1;
    for (int i = 0; i < 50 && !grant_n; i++) @(negedge core_clk);
    check({grant_n, addr_oe}, 2'b11);
    cyc(K_MRD, 20'h00010, 8'h00, 0);
    $display("hold test done");
  endtask : t_hold

  task automatic t_irq;
    logic [7:0] tab[8] = '{8'hBA, 8'hB0, 8'hD9, 8'hAA, 8'h34, 8'h3A, 8'hE9, 8'hF8};
    logic [2:0] t;
    for (int i = 0; i < 8; i++)
    begin
      @(posedge core_clk);
      {nmi_n, vectored_irq_zero_n, plain_irq_one_n, plain_irq_two_n, int_enable} <= tab[i][7:3];
      repeat (3) @(posedge core_clk);
      instr_end <= 1'b1;
      @(posedge core_clk);
      instr_end <= 1'b0;
      t = 3'h0;
      repeat (2)
      begin
        @(negedge core_clk);
        t = t | take;
      end
      check(t, tab[i][2:0]);
    end
    $display("interrupt test done");
  endtask : t_irq

  task automatic t_xfer;
    @(posedge core_clk);
    xfer_edge_mode <= 2'b10;
    xfer_request_zero_n <= 1'b0;
    xfer_request_one_n <= 1'b0;
    @(posedge core_clk);
    xfer_request_one_n <= 1'b1;
    repeat (3) @(negedge core_clk);
    check(xfer_ready, 2'b11);
    @(posedge core_clk);
    xfer_request_zero_n <= 1'b1;
    repeat (3) @(negedge core_clk);
    check(xfer_ready, 2'b10);
    cyc(K_DMAWR, 20'h80000, 8'h5A, 1);
    repeat (2) @(negedge core_clk);
    check(xfer_ready[1], 1'b0);
    $display("transfer request test done");
  endtask : t_xfer

  task automatic t_mode;
    @(posedge core_clk);
    cpu_mode <= M_HALT;
    repeat (4) @(negedge core_clk);
    check({cycle_kind_flag, stop_n, first_cycle_strobe_n}, 3'b000);
    @(posedge core_clk);
    cpu_mode <= M_SLEEP;
    repeat (4) @(negedge core_clk);
    check({cycle_kind_flag, stop_n, first_cycle_strobe_n, strobe_out, addr_out},
      {3'b101, 4'hF, SLEEP_ADDR});
    @(posedge core_clk);
    cpu_mode <= M_RUN;
    repeat (4) @(posedge core_clk);
    $display("halt and sleep test done");
  endtask : t_mode

  task automatic t_reset;
    @(posedge core_clk);
    reset_n <= 1'b0;
    @(negedge core_clk);
    check({addr_oe, data_oe, strobe_out, refresh_strobe_n, first_cycle_strobe_n, grant_n,
      enable_clk_out, system_clock_out}, 11'h1FC);
    @(posedge core_clk);
    reset_n <= 1'b1;
    $display("reset test done");
  endtask : t_reset

  // ==========================================
  // Main sequence
  initial
  begin
    {reset_n, clk_en, instr_end, int_enable, timer_out_sel, reload_timer_pulse} = 6'b010000;
    {hold_request_n, nmi_n, vectored_irq_zero_n, plain_irq_one_n, plain_irq_two_n} = 5'h1F;
    {xfer_request_zero_n, xfer_request_one_n} = 2'b11;
    req = '0;
    cpu_mode = M_RUN;
    xfer_edge_mode = 2'b00;
    wait_lim = 8'h01;
    rf_prev = 8'h00;
    rf_seen = 1'b0;
    failures = 0;
    check_count = 0;
    repeat (19) @(negedge core_clk);
    t_reset;
    t_clk;
    t_kinds;
    t_hold;
    t_irq;
    t_xfer;
    t_mode;
    t_reset;
    t_clk;
    cyc(K_FETCH1, 20'h01234, 8'h00, 0);
    complete_run;
  end
endmodule : tb_top
